// file: tldp_lane_debug.sv
// lane debug port: buffer status, eye scan, equaliser controls and apb registers
//
// Behaviour
// RQ1 - buffer status shows 000 nominal, 101 underflow, 110 overflow
// RQ2 - buffer status shows 001 below minimum latency, 010 above maximum latency
// RQ3 - eye scan error pulses one cycle per unmasked error while armed or counting
// RQ4 - user resets reconfiguration port after 500 silent cycles on read-only access
// RQ5 - buffer reset high then low resets only the elastic buffer state
// RQ6 - pll lock output high once frequency in tolerance; outputs untrusted before
// RQ7 - eye scan reset starts on deassertion after assertion, not on assertion
// RQ8 - one eye scan trigger event per trigger assertion
// RQ9 - digital monitor bus top index is 7 or 14 by family
// RQ10 - clock recovery value frozen while cdr hold is set
// RQ11 - gain hold: 00 adapts, 10 freezes, x1 applies configured gain
// RQ12 - gain override enable uses same encoding as gain hold
// RQ13 - boost hold 1 keeps boost, 0 lets it adapt
// RQ14 - equaliser reset high then low starts equaliser reset sequence
// RQ15 - high frequency control: 00 adapt, 10 freeze, x1 configured value
// RQ16 - low frequency control: 00 adapt, 10 freeze, x1 configured value
// RQ17 - monitor select 01 gain, 10 ut, 11 vp; 00 reserved
// RQ18 - user synchronises async status and stretches its reset pulses; here status is used unsynchronised, bufResetStart is one cycle
//
// The register offsets and the APB interface to the registers were left to the implementer.
`default_nettype none
module tldp_lane_debug #(
    parameter int DMON_MSB = 7,
    parameter int FILL_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pllInTolerance,
    input wire logic [FILL_W-1:0] bufFill,
    input wire logic bufUnderflowIn,
    input wire logic bufOverflowIn,
    input wire logic eyeErrIn,
    input wire logic eyeErrMask,
    input wire logic eyeTriggerIn,
    input wire tldp_pkg::tldp_loops_t loopsIn,
    output logic pllLock,
    output logic [2:0] bufStatus,
    output logic eyeScanError,
    output logic [DMON_MSB:0] dmonitorOut,
    output logic [6:0] monitorOut,
    output tldp_pkg::tldp_loops_t loopsOut,
    output logic bufResetStart,
    output logic irq
);
    import tldp_pkg::*;

    // refused at elaboration: the monitor slice and the fill compare only serve these widths
    if (!(DMON_MSB == 7 || DMON_MSB == 14) || FILL_W < 1 || FILL_W > 8) begin : g_bad_params
        $error("DMON_MSB must be 7 or 14 and FILL_W 1 to 8");
    end

    tldp_ctrl_t ctrl, prevCtrl;
    logic [7:0] clockCorrectionMinLatency, clockCorrectionMaxLatency;
    logic [6:0] equaliserGainSetting, linearEqHighFreqSetting, linearEqLowFreqSetting;
    logic [5:0] irqStatus, irqMask;
    logic [15:0] errCount;
    logic ovfSticky, udfSticky, prevTrigIn;
    tldp_eye_state_t eyeState;

    logic setupPhase, wrAccess, mapped;
    logic [31:0] readMux;
    logic eqResetStart, eyeResetStart, next_bufResetStart, triggerEvent, eyeErrHit;
    logic ovfAny, udfAny;
    logic [2:0] next_bufStatus;
    logic [5:0] events;
    logic [14:0] dmonVec;

    // apb decode; registers answer with one wait-free access phase
    assign setupPhase = psel && !penable;
    assign wrAccess = psel && penable && pready && pwrite;
    assign mapped = (paddr == TLDP_CTRL_OFF) || (paddr == TLDP_LATENCY_OFF) ||
                    (paddr == TLDP_EQSET_OFF) || (paddr == TLDP_STATUS_OFF) ||
                    (paddr == TLDP_IRQ_STATUS_OFF) || (paddr == TLDP_IRQ_MASK_OFF);

    always_comb begin
        readMux = 32'h0;
        unique case (paddr)
            TLDP_CTRL_OFF: begin
                readMux[15:0] = ctrl;
                readMux[TLDP_TRIGGER_BIT] = 1'b0;
            end
            TLDP_LATENCY_OFF: begin
                readMux[TLDP_LAT_MIN_LSB +: 8] = clockCorrectionMinLatency;
                readMux[TLDP_LAT_MAX_LSB +: 8] = clockCorrectionMaxLatency;
            end
            TLDP_EQSET_OFF: begin
                readMux[TLDP_EQ_GAIN_LSB +: 7] = equaliserGainSetting;
                readMux[TLDP_EQ_HF_LSB +: 7] = linearEqHighFreqSetting;
                readMux[TLDP_EQ_LF_LSB +: 7] = linearEqLowFreqSetting;
            end
            TLDP_STATUS_OFF: begin
                readMux[TLDP_ST_BUF_LSB +: 3] = bufStatus;
                readMux[TLDP_ST_LOCK_LSB] = pllLock;
                readMux[TLDP_ST_EYE_LSB +: 3] = eyeState;
                readMux[TLDP_ST_MON_LSB +: 7] = monitorOut;
                readMux[TLDP_ST_ERRCNT_LSB +: 16] = errCount;
            end
            TLDP_IRQ_STATUS_OFF: readMux[5:0] = irqStatus;
            TLDP_IRQ_MASK_OFF: readMux[5:0] = irqMask;
            default: readMux = 32'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= setupPhase;
            prdata <= setupPhase ? readMux : 32'h0;
            pslverr <= setupPhase && !mapped;
        end
    end

    // software control and settings; the trigger bit is a write-one pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl <= tldp_ctrl_t'(TLDP_CTRL_RST);
            clockCorrectionMinLatency <= TLDP_LAT_MIN_RST;
            clockCorrectionMaxLatency <= TLDP_LAT_MAX_RST;
            equaliserGainSetting <= TLDP_EQ_GAIN_RST;
            linearEqHighFreqSetting <= TLDP_EQ_HF_RST;
            linearEqLowFreqSetting <= TLDP_EQ_LF_RST;
            irqMask <= TLDP_IRQ_MASK_RST;
        end else if (ce) begin
            ctrl.eyeTrigger <= 1'b0;
            if (wrAccess) begin
                unique case (paddr)
                    TLDP_CTRL_OFF: ctrl <= tldp_ctrl_t'(pwdata[15:0]);
                    TLDP_LATENCY_OFF: begin
                        clockCorrectionMinLatency <= pwdata[TLDP_LAT_MIN_LSB +: 8];
                        clockCorrectionMaxLatency <= pwdata[TLDP_LAT_MAX_LSB +: 8];
                    end
                    TLDP_EQSET_OFF: begin
                        equaliserGainSetting <= pwdata[TLDP_EQ_GAIN_LSB +: 7];
                        linearEqHighFreqSetting <= pwdata[TLDP_EQ_HF_LSB +: 7];
                        linearEqLowFreqSetting <= pwdata[TLDP_EQ_LF_LSB +: 7];
                    end
                    TLDP_IRQ_MASK_OFF: irqMask <= pwdata[5:0];
                    default: ;
                endcase
            end
        end
    end

    // reset requests act on the falling edge of their control bit
    always_ff @(posedge clk) begin
        if (rst) begin
            prevCtrl <= tldp_ctrl_t'(TLDP_CTRL_RST);
            prevTrigIn <= 1'b0;
        end else if (ce) begin
            prevCtrl <= ctrl;
            prevTrigIn <= eyeTriggerIn;
        end
    end

    assign eqResetStart = ce && prevCtrl.eqReset && !ctrl.eqReset; // see RQ14
    assign eyeResetStart = ce && prevCtrl.eyeScanReset && !ctrl.eyeScanReset; // see RQ7
    assign next_bufResetStart = prevCtrl.bufReset && !ctrl.bufReset; // see RQ5
    // both the pin and the register bit give one event per assertion
    assign triggerEvent = (eyeTriggerIn && !prevTrigIn) || ctrl.eyeTrigger; // see RQ8

    always_ff @(posedge clk) begin
        if (rst) begin
            bufResetStart <= 1'b0;
        end else if (ce) begin
            bufResetStart <= next_bufResetStart;
        end
    end

    // pll lock follows the tolerance indication
    always_ff @(posedge clk) begin
        if (rst) begin
            pllLock <= 1'b0;
        end else if (ce) begin
            pllLock <= pllInTolerance; // see RQ6
        end
    end

    // elastic buffer: slips stay latched until a buffer reset or rst, nothing else clears them
    assign ovfAny = (ovfSticky || bufOverflowIn) && !next_bufResetStart;
    assign udfAny = (udfSticky || bufUnderflowIn) && !next_bufResetStart;

    always_ff @(posedge clk) begin
        if (rst) begin
            ovfSticky <= 1'b0;
            udfSticky <= 1'b0;
        end else if (ce && (pllLock || next_bufResetStart)) begin
            // a buffer reset must clear the slips even while unlocked
            ovfSticky <= ovfAny; // see RQ5
            udfSticky <= udfAny;
        end
    end

    // unlocked buffer data is meaningless, so report nominal until lock
    always_comb begin
        if (!pllLock) begin
            next_bufStatus = TLDP_BUF_NOMINAL; // see RQ6
        end else if (ovfAny) begin
            next_bufStatus = TLDP_BUF_OVERFLOW; // see RQ1
        end else if (udfAny) begin
            next_bufStatus = TLDP_BUF_UNDERFLOW; // see RQ1
        end else if (8'(bufFill) < clockCorrectionMinLatency) begin
            next_bufStatus = TLDP_BUF_BELOW_MIN; // see RQ2
        end else if (8'(bufFill) > clockCorrectionMaxLatency) begin
            next_bufStatus = TLDP_BUF_ABOVE_MAX; // see RQ2
        end else begin
            next_bufStatus = TLDP_BUF_NOMINAL;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bufStatus <= TLDP_BUF_NOMINAL;
        end else if (ce) begin
            bufStatus <= next_bufStatus;
        end
    end

    // eye scan: a reset arms it, triggers toggle between armed and counting
    always_ff @(posedge clk) begin
        if (rst) begin
            eyeState <= TLDP_EYE_IDLE;
        end else if (eyeResetStart) begin
            eyeState <= TLDP_EYE_ARMED; // see RQ7
        end else if (ce && triggerEvent) begin
            unique case (eyeState)
                TLDP_EYE_IDLE: eyeState <= TLDP_EYE_IDLE;
                TLDP_EYE_ARMED: eyeState <= TLDP_EYE_COUNT; // see RQ8
                TLDP_EYE_COUNT: eyeState <= TLDP_EYE_ARMED;
                default: eyeState <= TLDP_EYE_IDLE;
            endcase
        end
    end

    assign eyeErrHit = pllLock && eyeErrIn && !eyeErrMask &&
                       (eyeState == TLDP_EYE_ARMED || eyeState == TLDP_EYE_COUNT);

    always_ff @(posedge clk) begin
        if (rst) begin
            eyeScanError <= 1'b0;
            errCount <= 16'h0;
        end else if (ce) begin
            eyeScanError <= eyeErrHit; // see RQ3
            if (eyeResetStart) begin
                errCount <= 16'h0;
            end else if (eyeErrHit && eyeState == TLDP_EYE_COUNT && errCount != 16'hffff) begin
                errCount <= errCount + 16'h1;
            end
        end
    end

    // shared loop control: x1 applies the setting, 10 freezes, 00 adapts
    function automatic logic [6:0] loopSelect(input logic [1:0] mode, input logic [6:0] cur,
                                              input logic [6:0] adapt, input logic [6:0] cfg);
        logic [6:0] res;
        res = adapt;
        if (mode[0]) begin
            res = cfg;
        end else if (mode == TLDP_LOOP_FREEZE) begin
            res = cur;
        end
        return res;
    endfunction

    // equaliser and clock recovery loops; eq reset returns gains to start values
    // but leaves clock recovery alone, so one process owns the whole struct
    always_ff @(posedge clk) begin
        if (rst) begin
            loopsOut <= {TLDP_EQ_GAIN_RST, TLDP_EQ_HF_RST, TLDP_EQ_LF_RST, {4{TLDP_LOOP_RST}}};
        end else if (ce) begin
            if (eqResetStart) begin
                loopsOut.agc <= TLDP_EQ_GAIN_RST; // see RQ14
                loopsOut.hf <= TLDP_EQ_HF_RST;
                loopsOut.lf <= TLDP_EQ_LF_RST;
                loopsOut.boost <= TLDP_LOOP_RST;
                loopsOut.ut <= TLDP_LOOP_RST;
                loopsOut.vp <= TLDP_LOOP_RST;
            end else begin
                loopsOut.agc <= loopSelect(ctrl.agcHold | ctrl.agcOvrd, loopsOut.agc,
                                           loopsIn.agc, equaliserGainSetting); // see RQ11 RQ12
                loopsOut.hf <= loopSelect(ctrl.hfOvrd, loopsOut.hf,
                                          loopsIn.hf, linearEqHighFreqSetting); // see RQ15
                loopsOut.lf <= loopSelect(ctrl.lfOvrd, loopsOut.lf,
                                          loopsIn.lf, linearEqLowFreqSetting); // see RQ16
                loopsOut.boost <= ctrl.lfHold ? loopsOut.boost : loopsIn.boost; // see RQ13
                loopsOut.ut <= loopsIn.ut;
                loopsOut.vp <= loopsIn.vp;
            end
            if (!ctrl.cdrHold) begin
                loopsOut.cdr <= loopsIn.cdr; // see RQ10
            end
        end
    end

    // monitor routing; the reserved select drives zero
    always_ff @(posedge clk) begin
        if (rst) begin
            monitorOut <= 7'h0;
        end else if (ce) begin
            unique case (ctrl.monSel)
                TLDP_MON_AGC: monitorOut <= loopsOut.agc; // see RQ17
                TLDP_MON_UT: monitorOut <= loopsOut.ut;
                TLDP_MON_VP: monitorOut <= loopsOut.vp;
                default: monitorOut <= 7'h0;
            endcase
        end
    end

    // digital monitor: narrow family sees only the low slice
    assign dmonVec = {eyeState, bufStatus, pllLock, loopsOut.cdr, eyeScanError};

    always_ff @(posedge clk) begin
        if (rst) begin
            dmonitorOut <= '0;
        end else if (ce) begin
            dmonitorOut <= dmonVec[DMON_MSB:0]; // see RQ9
        end
    end

    // interrupt events; a set in the clearing cycle survives
    always_comb begin
        events = 6'h0;
        events[TLDP_IRQ_LOCK_GAIN] = pllInTolerance && !pllLock;
        events[TLDP_IRQ_LOCK_LOSS] = !pllInTolerance && pllLock;
        events[TLDP_IRQ_UNDERFLOW] = pllLock && bufUnderflowIn;
        events[TLDP_IRQ_OVERFLOW] = pllLock && bufOverflowIn;
        events[TLDP_IRQ_EYE_ERR] = eyeErrHit;
        events[TLDP_IRQ_LATENCY] = next_bufStatus == TLDP_BUF_BELOW_MIN ||
                                   next_bufStatus == TLDP_BUF_ABOVE_MAX;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irqStatus <= 6'h0;
        end else if (ce) begin
            if (wrAccess && paddr == TLDP_IRQ_STATUS_OFF) begin
                irqStatus <= (irqStatus & ~pwdata[5:0]) | events;
            end else begin
                irqStatus <= irqStatus | events;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(irqStatus & irqMask);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_eq_pulse;
        ce && ctrl.eqReset ##1 ce && !ctrl.eqReset;
    endsequence

    sequence s_eye_pulse;
        ce && ctrl.eyeScanReset ##1 ce && !ctrl.eyeScanReset;
    endsequence

    chk_buf_overflow_code: assert property ( // see RQ1
        ce && pllLock && bufOverflowIn && !next_bufResetStart |=> bufStatus == TLDP_BUF_OVERFLOW)
        else $error("overflow not reported");
    chk_buf_underflow_code: assert property ( // see RQ1
        ce && pllLock && !ovfAny && bufUnderflowIn && !next_bufResetStart
        |=> bufStatus == TLDP_BUF_UNDERFLOW)
        else $error("underflow not reported");
    chk_buf_latency_low: assert property ( // see RQ2
        ce && pllLock && !ovfAny && !udfAny && 8'(bufFill) < clockCorrectionMinLatency
        |=> bufStatus == TLDP_BUF_BELOW_MIN)
        else $error("below minimum latency not reported");
    chk_eye_error_pulse: assert property ( // see RQ3
        ce && eyeErrIn && !eyeErrMask && pllLock && eyeState != TLDP_EYE_IDLE
        |=> eyeScanError)
        else $error("eye scan error missed");
    chk_eye_idle_quiet: assert property ( // see RQ3
        ce && eyeState == TLDP_EYE_IDLE |=> !eyeScanError)
        else $error("eye scan error while idle");
    chk_eye_reset_fall: assert property ( // see RQ7
        s_eye_pulse |=> eyeState == TLDP_EYE_ARMED && errCount == 16'h0)
        else $error("eye scan reset did not start on release");
    chk_eye_reset_rise: assert property ( // see RQ7
        ce && ctrl.eyeScanReset && eyeState == TLDP_EYE_IDLE |=> eyeState == TLDP_EYE_IDLE)
        else $error("eye scan reset started on assertion");
    chk_eq_reset_seq: assert property ( // see RQ14
        s_eq_pulse |=> loopsOut.agc == TLDP_EQ_GAIN_RST && loopsOut.boost == TLDP_LOOP_RST)
        else $error("equaliser reset sequence not started");
    chk_cdr_frozen: assert property ( // see RQ10
        ce && ctrl.cdrHold |=> $stable(loopsOut.cdr))
        else $error("cdr moved while held");
    chk_gain_override: assert property ( // see RQ11
        ce && (ctrl.agcHold[0] || ctrl.agcOvrd[0]) && !eqResetStart
        |=> loopsOut.agc == $past(equaliserGainSetting))
        else $error("gain override not applied");
    chk_boost_hold: assert property ( // see RQ13
        ce && ctrl.lfHold && !eqResetStart |=> $stable(loopsOut.boost))
        else $error("boost moved while held");
    chk_monitor_route_ut: assert property ( // see RQ17
        ce && ctrl.monSel == TLDP_MON_UT |=> monitorOut == $past(loopsOut.ut))
        else $error("monitor not routed to ut loop");
    chk_lock_follow: assert property ( // see RQ6
        ce && pllInTolerance |=> pllLock)
        else $error("lock not asserted");
    chk_buf_reset_only: assert property ( // see RQ5
        ce && next_bufResetStart && ctrl.cdrHold |=> $stable(loopsOut.cdr) && !ovfSticky)
        else $error("buffer reset touched other state");
endmodule
`default_nettype wire

// file: tldp_pkg.sv
// package of constants and types for the transceiver lane debug port
`default_nettype none
package tldp_pkg;
    // register byte offsets
    localparam logic [7:0] TLDP_CTRL_OFF = 8'h00;
    localparam logic [7:0] TLDP_LATENCY_OFF = 8'h04;
    localparam logic [7:0] TLDP_EQSET_OFF = 8'h08;
    localparam logic [7:0] TLDP_STATUS_OFF = 8'h0c;
    localparam logic [7:0] TLDP_IRQ_STATUS_OFF = 8'h10;
    localparam logic [7:0] TLDP_IRQ_MASK_OFF = 8'h14;

    // field positions inside latency, equaliser setting, status and control words
    localparam int TLDP_LAT_MIN_LSB = 0;
    localparam int TLDP_LAT_MAX_LSB = 8;
    localparam int TLDP_EQ_GAIN_LSB = 0;
    localparam int TLDP_EQ_HF_LSB = 8;
    localparam int TLDP_EQ_LF_LSB = 16;
    localparam int TLDP_ST_BUF_LSB = 0;
    localparam int TLDP_ST_LOCK_LSB = 3;
    localparam int TLDP_ST_EYE_LSB = 4;
    localparam int TLDP_ST_MON_LSB = 8;
    localparam int TLDP_ST_ERRCNT_LSB = 16;
    localparam int TLDP_TRIGGER_BIT = 15;

    // reset values
    localparam logic [15:0] TLDP_CTRL_RST = 16'h0400;
    localparam logic [7:0] TLDP_LAT_MIN_RST = 8'h08;
    localparam logic [7:0] TLDP_LAT_MAX_RST = 8'h18;
    localparam logic [6:0] TLDP_EQ_GAIN_RST = 7'h10;
    localparam logic [6:0] TLDP_EQ_HF_RST = 7'h20;
    localparam logic [6:0] TLDP_EQ_LF_RST = 7'h20;
    localparam logic [6:0] TLDP_LOOP_RST = 7'h00;
    localparam logic [5:0] TLDP_IRQ_MASK_RST = 6'h00;

    // elastic buffer status codes
    localparam logic [2:0] TLDP_BUF_NOMINAL = 3'h0;
    localparam logic [2:0] TLDP_BUF_BELOW_MIN = 3'h1;
    localparam logic [2:0] TLDP_BUF_ABOVE_MAX = 3'h2;
    localparam logic [2:0] TLDP_BUF_UNDERFLOW = 3'h5;
    localparam logic [2:0] TLDP_BUF_OVERFLOW = 3'h6;

    // equaliser loop control codes (bit 0 set always overrides)
    localparam logic [1:0] TLDP_LOOP_ADAPT = 2'h0;
    localparam logic [1:0] TLDP_LOOP_FREEZE = 2'h2;

    // monitor select codes
    localparam logic [1:0] TLDP_MON_AGC = 2'h1;
    localparam logic [1:0] TLDP_MON_UT = 2'h2;
    localparam logic [1:0] TLDP_MON_VP = 2'h3;

    // interrupt status bit positions
    localparam int TLDP_IRQ_LOCK_GAIN = 0;
    localparam int TLDP_IRQ_LOCK_LOSS = 1;
    localparam int TLDP_IRQ_UNDERFLOW = 2;
    localparam int TLDP_IRQ_OVERFLOW = 3;
    localparam int TLDP_IRQ_EYE_ERR = 4;
    localparam int TLDP_IRQ_LATENCY = 5;

    typedef enum logic [2:0] {
        TLDP_EYE_IDLE = 3'b001,
        TLDP_EYE_ARMED = 3'b010,
        TLDP_EYE_COUNT = 3'b100
    } tldp_eye_state_t;

    // control word, bit 15 down to bit 0
    typedef struct packed {
        logic eyeTrigger;
        logic eqReset;
        logic eyeScanReset;
        logic bufReset;
        logic [1:0] monSel;
        logic [1:0] lfOvrd;
        logic [1:0] hfOvrd;
        logic [1:0] agcOvrd;
        logic [1:0] agcHold;
        logic lfHold;
        logic cdrHold;
    } tldp_ctrl_t;

    // adaptive loop values arriving from the receiver
    typedef struct packed {
        logic [6:0] agc;
        logic [6:0] hf;
        logic [6:0] lf;
        logic [6:0] boost;
        logic [6:0] cdr;
        logic [6:0] ut;
        logic [6:0] vp;
    } tldp_loops_t;
endpackage
`default_nettype wire

// file: tldp_rx_model.sv
// receiver model feeding adaptive loop values that drift every cycle
`default_nettype none
module tldp_rx_model (
    input wire logic clk,
    input wire logic rst,
    output tldp_pkg::tldp_loops_t loopsIn
);
    timeunit 1ns;
    timeprecision 1ps;
    import tldp_pkg::*;
    logic [6:0] step;
    always_ff @(posedge clk) begin
        if (rst) begin
            step <= 7'h00;
        end else begin
            step <= step + 7'h05;
        end
    end
    // every loop moves each cycle, so a frozen value can never pass for a forwarded one
    assign loopsIn = {step, step ^ 7'h11, step ^ 7'h22, step ^ 7'h33, step ^ 7'h44,
        step ^ 7'h55, step ^ 7'h66};
endmodule
`default_nettype wire

// file: test_tldp_lane_debug.sv
// self-checking bench for the lane debug port
`default_nettype none
module test_tldp_lane_debug;
    timeunit 1ns;
    timeprecision 1ps;
    import tldp_pkg::*;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pll = 0, ce = 1;
    logic udf = 0, ovf = 0, err = 0, msk = 0, trg = 0, pready, pslverr, slvErr;
    logic pllLock, eyeScanError, bufResetStart, irq;
    logic [7:0] paddr = 0, fill = 8'h10;
    logic [31:0] pwdata = 0, prdata, rdq;
    logic [2:0] bufStatus;
    logic [14:0] dmon;
    logic [6:0] mon;
    logic [1:0] m;
    tldp_loops_t loopsIn, loopsOut, pi, po;
    int numErrors = 0, checksDone = 0, n;
    logic [12:0] rows [8] = '{{8'h04, 2'b00, TLDP_BUF_BELOW_MIN}, {8'h30, 2'b00, TLDP_BUF_ABOVE_MAX},
        {8'h08, 2'b00, TLDP_BUF_NOMINAL}, {8'h18, 2'b00, TLDP_BUF_NOMINAL},
        {8'h10, 2'b10, TLDP_BUF_UNDERFLOW}, {8'h04, 2'b10, TLDP_BUF_UNDERFLOW},
        {8'h10, 2'b01, TLDP_BUF_OVERFLOW}, {8'h10, 2'b00, TLDP_BUF_OVERFLOW}};
    tldp_lane_debug #(.DMON_MSB(14), .FILL_W(8)) uut (.clk(clk), .rst(rst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pllInTolerance(pll),
        .bufFill(fill), .bufUnderflowIn(udf), .bufOverflowIn(ovf), .eyeErrIn(err),
        .eyeErrMask(msk), .eyeTriggerIn(trg), .loopsIn(loopsIn), .pllLock(pllLock),
        .bufStatus(bufStatus), .eyeScanError(eyeScanError), .dmonitorOut(dmon),
        .monitorOut(mon), .loopsOut(loopsOut), .bufResetStart(bufResetStart), .irq(irq));
    tldp_rx_model rx (.clk(clk), .rst(rst), .loopsIn(loopsIn));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic stopTest;
        if (numErrors == 0 && checksDone > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            numErrors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // one apb transfer; read data and error are taken at the edge that sees pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int w;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge clk);
        penable <= 1;
        w = 0;
        do begin
            @(posedge clk);
            w++;
        end while (pready !== 1'b1 && w < 20);
        rdq = prdata;
        slvErr = pslverr;
        {psel, penable} <= 2'b00;
        if (w >= 20) begin
            numErrors++;
            stopTest();
        end
    endtask
    task automatic pulseErr(input logic mk);
        @(posedge clk);
        err <= 1;
        msk <= mk;
        n = 0;
        repeat (4) begin
            @(posedge clk);
            err <= 0;
            #1;
            n += eyeScanError;
        end
    endtask
    function automatic logic [6:0] want(input logic [1:0] md, input logic [6:0] i, o, c);
        return md[0] ? c : (md[1] ? o : i);
    endfunction
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        pll <= 1;
        #1;
        chk(pllLock, 0);
        tick(1);
        chk(pllLock, 1);
        apb(0, TLDP_CTRL_OFF, 0);
        chk(rdq, TLDP_CTRL_RST);
        apb(0, TLDP_EQSET_OFF, 0);
        chk(rdq, {9'h0, TLDP_EQ_LF_RST, 1'b0, TLDP_EQ_HF_RST, 1'b0, TLDP_EQ_GAIN_RST});
        apb(0, 8'hfc, 0);
        chk(slvErr, 1);
        chk(rdq, 0);
        foreach (rows[i]) begin
            @(posedge clk);
            {fill, udf, ovf} <= rows[i][12:3];
            tick(2);
            chk(bufStatus, rows[i][2:0]);
        end
        apb(1, TLDP_IRQ_MASK_OFF, 32'h08);
        tick(1);
        chk(irq, 1);
        apb(1, TLDP_IRQ_STATUS_OFF, 32'h3f);
        tick(1);
        chk(irq, 0);
        apb(1, TLDP_CTRL_OFF, 32'h1401);
        tick(1);
        chk(bufResetStart, 0);
        apb(1, TLDP_CTRL_OFF, 32'h0401);
        tick(1);
        chk(bufResetStart, 1);
        tick(1);
        chk({bufResetStart, bufStatus}, 0);
        apb(1, TLDP_CTRL_OFF, 32'h2400);
        apb(0, TLDP_STATUS_OFF, 0);
        chk(rdq[6:4], 3'b001);
        apb(1, TLDP_CTRL_OFF, 32'h0400);
        apb(0, TLDP_STATUS_OFF, 0);
        chk(rdq[6:4], 3'b010);
        chk(dmon[14:12], 3'b010);
        pulseErr(0);
        chk(n, 1);
        pulseErr(1);
        chk(n, 0);
        apb(1, TLDP_CTRL_OFF, 32'h8400);
        apb(0, TLDP_STATUS_OFF, 0);
        chk(rdq[6:4], 3'b100);
        trg <= 1;
        apb(0, TLDP_STATUS_OFF, 0);
        chk(rdq[6:4], 3'b010);
        apb(1, TLDP_EQSET_OFF, 32'h00554433);
        for (int k = 0; k < 4; k++) begin
            m = k[1:0];
            apb(1, TLDP_CTRL_OFF, 32'h0400 | {m, m, 2'b00, m, m});
            tick(2);
            pi = loopsIn;
            po = loopsOut;
            tick(1);
            chk(loopsOut.agc, want(m, pi.agc, po.agc, 7'h33));
            chk(loopsOut.hf, want(m, pi.hf, po.hf, 7'h44));
            chk(loopsOut.lf, want(m, pi.lf, po.lf, 7'h55));
            chk(loopsOut.cdr, m[0] ? po.cdr : pi.cdr);
            chk(loopsOut.boost, m[1] ? po.boost : pi.boost);
        end
        apb(1, TLDP_CTRL_OFF, 32'h0410);
        tick(2);
        chk(loopsOut.agc, 7'h33);
        apb(1, TLDP_CTRL_OFF, 32'h4688);
        apb(1, TLDP_CTRL_OFF, 32'h0688);
        tick(2);
        chk({loopsOut.agc, loopsOut.hf, loopsOut.lf}, {7'h10, 7'h20, 7'h20});
        for (int s = 1; s < 4; s++) begin
            apb(1, TLDP_CTRL_OFF, 32'(s) << 10);
            tick(2);
            po = loopsOut;
            tick(1);
            chk(mon, s == 1 ? po.agc : (s == 2 ? po.ut : po.vp));
        end
        // clock enable low must freeze the recovery loop although the receiver keeps moving
        @(posedge clk);
        ce <= 0;
        tick(1);
        po = loopsOut;
        tick(2);
        chk(loopsOut.cdr, po.cdr);
        stopTest();
    end
endmodule
`default_nettype wire
